// >>> sim/testbench.sv
// self-checking bench for the tone key decoder output section
// assumes short millisecond counts: 8 aclk cycles or 2 pin edges per ms
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_clk, ext_run;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, lcode, seen;
  logic awready, wready, bvalid, arready, rvalid, c0, c1, c2, c3, tp, oe, ltp;
  logic [1:0] bresp, rresp, r;
  tkd_pkg::tkd_det_t det;
  int miscompares, comparisons, n;
  // row = low tone, column = high tone
  localparam logic [63:0] KT = 64'hDF0E_C987_B654_A321;
  tkd_top #(.CYC_PER_MS(8), .EXT_EDGES_PER_MS(2)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .det_in(det), .external_clock_input(ext_clk), .key_code_bit0(c0),
    .key_code_bit1(c1), .key_code_bit2(c2), .key_code_bit3(c3), .tone_present(tp), .outputs_oe(oe));
  tkd_key_scanner far (.aclk(aclk), .aresetn(aresetn), .code_pins({c3, c2, c1, c0}), .tp_pin(tp),
    .oe_pin(oe), .line_code(lcode), .line_tp(ltp), .seen_code(seen));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // pin clock unrelated in phase to aclk; static while stopped
  initial begin
    ext_clk = 1'b0;
    forever #4.9 if (ext_run) ext_clk = ~ext_clk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
    comparisons++;
    if (seen_v !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask
  task automatic hang(input string nm);
    miscompares++;
    $display("Error %s expected answer seen none", nm);
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int k;
    bit got;
    k = 0;
    got = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && k < 50) begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
    if (!got) hang("write");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int k;
    bit got;
    k = 0;
    got = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && k < 50) begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1;
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) hang("read");
  endtask
  // counts cycles until tone present reaches the given level
  task automatic wait_tp(input logic v, input int lim, output int k);
    k = 0;
    while (tp !== v && k < lim) begin
      @(posedge aclk);
      k++;
    end
    if (tp !== v) hang("tone_present");
  endtask
  task automatic tone(input logic on, input logic [3:0] key);
    @(posedge aclk);
    det <= {on, key};
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ext_run} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    det = '0;
    miscompares = 0;
    comparisons = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r);
    chk("ctrl reset", d, 32'h4);
    wr(8'h00, 32'h6, r);
    tone(1'b1, 4'h5);
    repeat (20) @(posedge aclk);
    chk("oe in reset", oe, 1'b0);
    chk("tp in reset", tp, 1'b0);
    tone(1'b0, 4'h5);
    wr(8'h00, 32'hE, r);
    repeat (20) @(posedge aclk);
    chk("oe driven", oe, 1'b1);
    chk("tp after reset", tp, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      tone(1'b1, i[3:0]);
      wait_tp(1'b1, 10, n);
      repeat (20 + i * 8) @(posedge aclk);
      chk("key code", seen, {28'h0, KT[i*4+:4]});
      chk("code stable", {c3, c2, c1, c0}, {28'h0, KT[i*4+:4]});
      chk("line code", lcode, {28'h0, KT[i*4+:4]});
      chk("tp follows", tp, 1'b1);
      tone(1'b0, i[3:0]);
      wait_tp(1'b0, 300, n);
      chk("release delay", (n >= 27 * 8 && n <= 28 * 8 + 6), 1'b1);
    end
    $display("test keys done");
    wr(8'h00, 32'hC, r);
    tone(1'b1, 4'h3);
    wait_tp(1'b1, 10, n);
    tone(1'b0, 4'h3);
    wait_tp(1'b0, 400, n);
    chk("fixed short", (n >= 41 * 8 - 4 && n <= 42 * 8 + 4), 1'b1);
    tone(1'b1, 4'hE);
    wait_tp(1'b1, 10, n);
    rd(8'h04, d, r);
    chk("status", d, 32'h3F);
    wr(8'h00, 32'hD, r);
    repeat (3) @(posedge aclk);
    chk("oe muted", oe, 1'b0);
    wr(8'h00, 32'hC, r);
    wait_tp(1'b0, 400, n);
    chk("fixed long tone", (n >= 41 * 8 - 16 && n <= 42 * 8 - 12), 1'b1);
    tone(1'b0, 4'hE);
    repeat (20) @(posedge aclk);
    $display("test fixed and mute done");
    wr(8'h00, 32'hA, r);
    tone(1'b1, 4'h9);
    wait_tp(1'b1, 10, n);
    tone(1'b0, 4'h9);
    repeat (400) @(posedge aclk);
    chk("ext clock stopped", tp, 1'b1);
    ext_run = 1'b1;
    wait_tp(1'b0, 600, n);
    ext_run = 1'b0;
    chk("ext clock release", tp, 1'b0);
    $display("test clock select done");
    wr(8'h10, 32'h0, r);
    chk("bad write", r, 2'h3);
    wr(8'h04, 32'h0, r);
    chk("status write", r, 2'h0);
    rd(8'h10, d, r);
    chk("bad read resp", r, 2'h3);
    chk("bad read data", d, 32'h0);
    rd(8'h00, d, r);
    chk("ctrl kept", d, 32'hA);
    $display("test bus done");
    results();
  end
endmodule

// >>> sim/tkd_key_scanner.sv
// far-side logic that scans the decoded key outputs
// assumes the five output pins and their shared enable from the decoder
module tkd_key_scanner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] code_pins,
  input wire logic tp_pin,
  input wire logic oe_pin,
  output logic [3:0] line_code,
  output logic line_tp,
  output logic [3:0] seen_code
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] last_code_r;
  logic last_tp_r;
  logic tp_q_r;
  // ****************
  // wire levels
  // ****************
  // floated lines have no pull: show a pattern that flips every cycle
  assign line_code = oe_pin ? code_pins : ~last_code_r;
  assign line_tp = oe_pin ? tp_pin : ~last_tp_r;
  // reset gives the floated lines a known start, so the flip pattern is never unknown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_code_r <= 4'h0;
      last_tp_r <= 1'b0;
    end else begin
      last_code_r <= line_code;
      last_tp_r <= line_tp;
    end
  end
  // ****************
  // key capture
  // ****************
  // sample only on a driven rising tone present edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tp_q_r <= 1'b0;
      seen_code <= 4'h0;
    end else begin
      tp_q_r <= line_tp;
      if (line_tp && !tp_q_r && oe_pin) begin
        seen_code <= line_code;
      end
    end
  end
endmodule

// >>> src/tkd_defines.svh
// constants for the tone key decoder output section
// assumes a 250 MHz aclk and an AXI4-Lite master with 32-bit data
`ifndef TKD_DEFINES_SVH
`define TKD_DEFINES_SVH
`define TKD_CLK_HZ 250000000
`define TKD_EXT_HZ 3579545
`define TKD_MS_PER_S 1000
`define TKD_TICK_MS 1
`define TKD_FIXED_MS 42
`define TKD_RELEASE_MS 28
`define TKD_TMR_W 8
`define TKD_CTRL_OFS 8'h00
`define TKD_STAT_OFS 8'h04
`define TKD_CTRL_W 4
`define TKD_CTRL_RST 4'h4
`define TKD_RESP_OKAY 2'h0
`define TKD_RESP_DECERR 2'h3
`endif

// >>> src/tkd_hold_timer.sv
// millisecond down-counter for output hold and release delays
// assumes tick is a one-cycle enable once per millisecond on aclk
module tkd_hold_timer #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic load,
  input wire logic cancel,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic busy_r;
  logic done_r;

  generate
    if (W < 2) begin : g_chk
      $error("tkd_hold_timer: W too small");
    end
  endgenerate

  // a load restarts the count; first tick may come early, so hold is val-1..val ms
  always_ff @(posedge aclk) begin
    if (!aresetn || cancel) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else if (load) begin
      cnt_r <= load_val;
      busy_r <= 1'b1;
    end else if (busy_r && tick) begin
      cnt_r <= cnt_r - W'(1);
      if (cnt_r <= W'(1)) begin
        busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cancel || load) begin
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && tick && (cnt_r <= W'(1));
    end
  end

  assign done = done_r;
endmodule

// >>> src/tkd_pkg.sv
// types shared by the tone key decoder output section
// assumes nothing beyond a SystemVerilog elaborator
package tkd_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_FOLLOW, ST_RELEASE, ST_FIXED, ST_GAP} tkd_state_t;

  // detector bundle from the analog path: tone pair present and group indices
  typedef struct packed {
    logic valid;
    logic [1:0] low;
    logic [1:0] high;
  } tkd_det_t;

  typedef struct packed {
    logic por_n;
    logic clk_sel;
    logic len_sel;
    logic mute;
  } tkd_ctrl_t;

  // row = low group, column = high group
  function automatic logic [3:0] tkd_key(input logic [1:0] low, input logic [1:0] high);
    logic [3:0] k;
    k = 4'h0;
    unique case ({low, high})
      4'h0: k = 4'h1;
      4'h1: k = 4'h2;
      4'h2: k = 4'h3;
      4'h3: k = 4'hA;
      4'h4: k = 4'h4;
      4'h5: k = 4'h5;
      4'h6: k = 4'h6;
      4'h7: k = 4'hB;
      4'h8: k = 4'h7;
      4'h9: k = 4'h8;
      4'hA: k = 4'h9;
      4'hB: k = 4'hC;
      4'hC: k = 4'hE;
      4'hD: k = 4'h0;
      4'hE: k = 4'hF;
      4'hF: k = 4'hD;
    endcase
    return k;
  endfunction
endpackage

// >>> src/tkd_top.sv
// tone key decoder output section: key code, tone present, float and length control
// assumes detector bundle and external clock arrive asynchronously; AXI4-Lite on aclk
//
// Function
// - mute high floats all four key code outputs and tone present.
// - mute low with reset inactive drives all five outputs.
// - power-on reset low floats the outputs whatever mute says.
// - length select high keeps outputs valid as long as the tone lasts.
// - length select low shows outputs for a fixed time regardless of tone length.
// - clock select low times from external clock, high from internal oscillator.
// - each key is a 4-bit code on the outputs; pound encodes as all ones.
// - tone present is asserted while a valid tone pair is reported; with length select low it drops after the fixed time.
// - 16 keys from four low and four high tones, mapped per the code table.
// - in tone-following mode outputs release 21 to 35 ms after the tone ends.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`include "tkd_defines.svh"
module tkd_top #(
  parameter int CYC_PER_MS = `TKD_CLK_HZ / `TKD_MS_PER_S,
  parameter int EXT_EDGES_PER_MS = `TKD_EXT_HZ / `TKD_MS_PER_S,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tkd_pkg::tkd_det_t det_in,
  input wire logic external_clock_input,
  output logic key_code_bit0,
  output logic key_code_bit1,
  output logic key_code_bit2,
  output logic key_code_bit3,
  output logic tone_present,
  output logic outputs_oe
);
  localparam int CNT_W = 32;
  localparam int FIXED_TICKS = `TKD_FIXED_MS / `TKD_TICK_MS;
  localparam int RELEASE_TICKS = `TKD_RELEASE_MS / `TKD_TICK_MS;

  generate
    if (CYC_PER_MS < 2 || EXT_EDGES_PER_MS < 1 || ADDR_W < 3) begin : g_chk
      $error("tkd_top: parameter out of range");
    end
  endgenerate

  // ****************************************
  // pin synchronisers
  // ****************************************
  tkd_pkg::tkd_det_t det_s1_r;
  tkd_pkg::tkd_det_t det_s;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_s1_r <= '0;
      det_s <= '0;
    end else begin
      det_s1_r <= det_in;
      det_s <= det_s1_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_clock_input;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  tkd_pkg::tkd_ctrl_t ctrl_r;
  tkd_pkg::tkd_state_t state_r;
  logic tp_r;
  logic [3:0] code_r;
  logic oe_r;
  logic awready_r;
  logic arready_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [1:0] bresp_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_go;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;

  // address and data are taken together, one cycle after both are offered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
    end else begin
      awready_r <= wr_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= tkd_pkg::tkd_ctrl_t'(`TKD_CTRL_RST);
    end else if (awready_r && s_axi_awaddr == `TKD_CTRL_OFS && s_axi_wstrb[0]) begin
      ctrl_r <= tkd_pkg::tkd_ctrl_t'(s_axi_wdata[`TKD_CTRL_W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `TKD_RESP_OKAY;
    end else if (awready_r) begin
      bvalid_r <= 1'b1;
      bresp_r <= (s_axi_awaddr == `TKD_CTRL_OFS || s_axi_awaddr == `TKD_STAT_OFS) ?
                 `TKD_RESP_OKAY : `TKD_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
    end else begin
      arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= `TKD_RESP_OKAY;
      rdata_r <= 32'h0;
    end else if (arready_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= `TKD_RESP_OKAY;
      if (s_axi_araddr == `TKD_CTRL_OFS) begin
        rdata_r <= {28'h0, ctrl_r};
      end else if (s_axi_araddr == `TKD_STAT_OFS) begin
        rdata_r <= {26'h0, oe_r, tp_r, code_r};
      end else begin
        rdata_r <= 32'h0;
        rresp_r <= `TKD_RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // millisecond timebase
  // ****************************************
  logic [CNT_W-1:0] int_cnt_r;
  logic [CNT_W-1:0] ext_cnt_r;
  logic int_tick;
  logic ext_rise;
  logic ext_tick;
  logic ms_tick;

  assign ext_rise = ext_s2_r && !ext_s3_r;
  assign int_tick = int_cnt_r == CNT_W'(CYC_PER_MS - 1);
  assign ext_tick = ext_rise && ext_cnt_r == CNT_W'(EXT_EDGES_PER_MS - 1);
  assign ms_tick = ctrl_r.clk_sel ? int_tick : ext_tick;

  // internal source stands in for the on-chip oscillator; the idle one is held at zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.clk_sel || int_tick) begin
      int_cnt_r <= '0;
    end else begin
      int_cnt_r <= int_cnt_r + CNT_W'(1);
    end
  end

  // a static external pin never ticks, so a tied input is harmless when unused
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_r.clk_sel || ext_tick) begin
      ext_cnt_r <= '0;
    end else if (ext_rise) begin
      ext_cnt_r <= ext_cnt_r + CNT_W'(1);
    end
  end

  // ****************************************
  // output sequencing
  // ****************************************
  logic tmr_load;
  logic tmr_done;
  logic [`TKD_TMR_W-1:0] tmr_val;

  always_comb begin
    tmr_load = 1'b0;
    tmr_val = `TKD_TMR_W'(FIXED_TICKS);
    if (ctrl_r.por_n) begin
      if (state_r == tkd_pkg::ST_IDLE && det_s.valid && !ctrl_r.len_sel) begin
        tmr_load = 1'b1;
      end else if (state_r == tkd_pkg::ST_FOLLOW && !det_s.valid) begin
        tmr_load = 1'b1;
        tmr_val = `TKD_TMR_W'(RELEASE_TICKS);
      end
    end
  end

  tkd_hold_timer #(.W(`TKD_TMR_W)) u_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(ms_tick),
    .load(tmr_load),
    .cancel(!ctrl_r.por_n || (state_r == tkd_pkg::ST_RELEASE && det_s.valid)),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // fixed mode waits for the tone to end after the hold, so one key gives one report
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.por_n) begin
      state_r <= tkd_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        tkd_pkg::ST_IDLE:
          if (det_s.valid) begin
            state_r <= ctrl_r.len_sel ? tkd_pkg::ST_FOLLOW : tkd_pkg::ST_FIXED;
          end
        tkd_pkg::ST_FOLLOW:
          if (!det_s.valid) begin
            state_r <= tkd_pkg::ST_RELEASE;
          end
        tkd_pkg::ST_RELEASE:
          if (det_s.valid) begin
            state_r <= tkd_pkg::ST_FOLLOW;
          end else if (tmr_done) begin
            state_r <= tkd_pkg::ST_IDLE;
          end
        tkd_pkg::ST_FIXED:
          if (tmr_done) begin
            state_r <= tkd_pkg::ST_GAP;
          end
        tkd_pkg::ST_GAP:
          if (!det_s.valid) begin
            state_r <= tkd_pkg::ST_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.por_n) begin
      tp_r <= 1'b0;
    end else if (state_r == tkd_pkg::ST_IDLE && det_s.valid) begin
      tp_r <= 1'b1;
    end else if (tmr_done && !(state_r == tkd_pkg::ST_RELEASE && det_s.valid)) begin
      tp_r <= 1'b0;
    end
  end

  // code loads only on the edge that raises tone present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_r <= 4'h0;
    end else if (ctrl_r.por_n && state_r == tkd_pkg::ST_IDLE && det_s.valid) begin
      code_r <= tkd_pkg::tkd_key(det_s.low, det_s.high);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= ctrl_r.por_n && !ctrl_r.mute;
    end
  end

  assign {key_code_bit3, key_code_bit2, key_code_bit1, key_code_bit0} = code_r;
  assign tone_present = tp_r;
  assign outputs_oe = oe_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ****************************************
  // checks
  // ****************************************
  chk_mute_float: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r.mute |=> !outputs_oe) else $error("outputs driven while muted");
  chk_drive_active: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_r.por_n && !ctrl_r.mute |=> outputs_oe) else $error("outputs not driven");
  chk_por_float: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r.por_n |=> !outputs_oe && !tone_present) else $error("outputs active in reset");
  chk_follow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == tkd_pkg::ST_FOLLOW |-> tone_present) else $error("follow mode dropped output");
  chk_fixed_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == tkd_pkg::ST_FIXED && !tmr_done && ctrl_r.por_n |=> tone_present)
    else $error("fixed output ended early");
  chk_clk_source: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r.clk_sel && !ext_rise |-> !ms_tick) else $error("tick without external edge");
  chk_key_map: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tone_present) |-> code_r == tkd_pkg::tkd_key($past(det_s.low), $past(det_s.high)))
    else $error("key code mismatch");
  chk_tone_start: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == tkd_pkg::ST_IDLE && det_s.valid && ctrl_r.por_n |=> tone_present ##1 tone_present)
    else $error("tone present not raised");
  chk_code_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    tone_present && $past(tone_present) |-> code_r == $past(code_r)) else $error("code moved");
  chk_release_end: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == tkd_pkg::ST_RELEASE && tmr_done && !det_s.valid |=> !tone_present)
    else $error("release delay overrun");
  chk_por_start: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ctrl_r.por_n) |-> !tone_present ##1 !tone_present) else $error("tone present after reset");
endmodule
